// >>> rtl/irq_priority_standby_wake.sv
// Interrupt priority resolution, vector request and standby mode control.
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
module irq_priority_standby_wake
    import irq_wake_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins and system reset sources.
    input wire logic res_n_i,
    input wire logic wdt_rst_i,
    input wire logic ext_irq_in_0_i,
    input wire logic ext_irq_in_1_i,
    input wire logic ext_irq_in_2_i,
    input wire logic ext_irq_in_4_i,
    input wire logic ext_irq_in_5_i,
    // Peripheral event pulses, one per source.
    input wire logic [NUM_SRC-1:0] periph_evt_i,
    // CPU vector handshake.
    output vec_req_s vec_o,
    input wire logic vec_ack_i,
    input wire logic reti_i,
    output logic irq_o,
    // Standby controls.
    output logic cpu_run_o,
    output logic periph_run_o,
    output logic keep_alive_run_o,
    output logic osc_cf_en_o,
    output logic osc_rc_en_o,
    output logic osc_xt_en_o
);
    // Byte lane enable expanded to a bit mask.
    function automatic logic [31:0] sel_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++)
        begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction : sel_mask

    // Level assigned to a vector by its select bit.
    function automatic level_e vec_level(input int v, input logic up);
        if (!up)
            return LVL_L;
        return (v < 2) ? LVL_X : LVL_H;
    endfunction : vec_level

    // Sources whose logic keeps running in a given mode.
    function automatic logic [23:0] run_src_mask(input standby_e m, input logic [1:0] lvl01);
        logic [23:0] r;
        r = '1;
        case (m)
            MODE_RUN, MODE_HALT: r = '1;
            MODE_HOLD: r = HOLD_WAKE_SRC;
            MODE_XHOLD: r = HOLD_WAKE_SRC | XHOLD_EXTRA_SRC;
            default: r = '1;
        endcase
        if (m == MODE_HOLD || m == MODE_XHOLD)
        begin
            r[1:0] = r[1:0] & lvl01;
        end
        return r;
    endfunction : run_src_mask

    logic [5:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
    logic sys_rst;
    logic [NUM_EXT-1:0] ext_evt;
    logic [23:0] src_raw, src_set, flag_reg, mask_reg, flag_next;
    logic [NUM_VEC-1:0] lvlsel_reg, pend_vec;
    logic cf_off_reg, xt_off_reg, rc_off_reg;
    logic [NUM_EXT-1:0] lvldet_reg;
    standby_e mode_reg, mode_next;
    logic [2:0] serv_reg;
    level_e cur_lvl, best_lvl;
    logic [3:0] best_num, last_vec_reg;
    logic best_valid, accept;
    logic wb_req, wr_ctrl;
    logic [31:0] wmask, rd_data;

    // Pins cross in through two flops; the second feeds edge detection.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_meta_reg <= PIN_IDLE;
            pin_sync_reg <= PIN_IDLE;
            pin_prev_reg <= PIN_IDLE;
        end
        else
        begin
            pin_meta_reg <= {ext_irq_in_5_i, ext_irq_in_4_i, ext_irq_in_2_i,
                             ext_irq_in_1_i, ext_irq_in_0_i, res_n_i};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Reset pin low, watchdog or bus reset all act as a system reset.
    assign sys_rst = rst_i | ~pin_sync_reg[0] | wdt_rst_i;

    // External event: high level or rising edge, per detection bit.
    generate
        for (genvar i = 0; i < NUM_EXT; i++)
        begin : g_ext
            assign ext_evt[i] = lvldet_reg[i] ? pin_sync_reg[i+1]
                                              : pin_sync_reg[i+1] & ~pin_prev_reg[i+1];
        end
    endgenerate

    // Merge pins into the source vector; stopped peripherals raise nothing.
    always_comb
    begin
        src_raw = periph_evt_i;
        for (int i = 0; i < NUM_EXT; i++)
        begin
            src_raw[EXT_SRC[i]] = ext_evt[i];
        end
        src_set = src_raw & run_src_mask(mode_reg, lvldet_reg[1:0]);
    end

    // Bus decode; a write lands on the edge that raises acknowledge.
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wmask = sel_mask(wb_sel_i);
    assign wr_ctrl = wb_req & wb_we_i & (wb_adr_i == ADDR_CTRL);

    // Sticky flags; a new event wins over a clear in the same cycle.
    always_comb
    begin
        flag_next = flag_reg;
        if (wb_req && wb_we_i && wb_adr_i == ADDR_FLAG)
        begin
            flag_next = flag_next & ~wb_dat_i[23:0] | ~wmask[23:0] & flag_next;
        end
        flag_next = flag_next | src_set;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
            flag_reg <= '0;
        else
            flag_reg <= flag_next;
    end

    // Software-written configuration.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
        begin
            mask_reg <= '0;
            lvlsel_reg <= '0;
            cf_off_reg <= 1'b0;
            xt_off_reg <= 1'b0;
            rc_off_reg <= 1'b0;
            lvldet_reg <= '0;
        end
        else if (wb_req && wb_we_i)
        begin
            if (wb_adr_i == ADDR_MASK)
                mask_reg <= (mask_reg & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
            if (wb_adr_i == ADDR_LEVEL)
                lvlsel_reg <= (lvlsel_reg & ~wmask[9:0]) | (wb_dat_i[9:0] & wmask[9:0]);
            if (wr_ctrl && wb_sel_i[0])
            begin
                cf_off_reg <= wb_dat_i[CTRL_CF_OFF];
                xt_off_reg <= wb_dat_i[CTRL_XT_OFF];
                rc_off_reg <= wb_dat_i[CTRL_RC_OFF];
            end
            if (wr_ctrl && wb_sel_i[1])
                lvldet_reg <= wb_dat_i[CTRL_LVLDET_LSB +: NUM_EXT];
        end
    end

    // Per-vector pending from enabled flags.
    generate
        for (genvar v = 0; v < NUM_VEC; v++)
        begin : g_vec
            assign pend_vec[v] = |(flag_reg & mask_reg & VEC_SRC_MASK[v]);
        end
    endgenerate

    // Highest in-service level; bit 2 is X, bit 1 H, bit 0 L.
    always_comb
    begin
        if (serv_reg[2])
            cur_lvl = LVL_X;
        else if (serv_reg[1])
            cur_lvl = LVL_H;
        else if (serv_reg[0])
            cur_lvl = LVL_L;
        else
            cur_lvl = LVL_NONE;
    end

    // Scan from the top vector down so equal levels settle on the smallest.
    always_comb
    begin
        best_valid = 1'b0;
        best_lvl = LVL_NONE;
        best_num = '0;
        for (int v = NUM_VEC - 1; v >= 0; v--)
        begin
            if (pend_vec[v] && vec_level(v, lvlsel_reg[v]) >= best_lvl)
            begin
                best_valid = 1'b1;
                best_lvl = vec_level(v, lvlsel_reg[v]);
                best_num = 4'(v);
            end
        end
        accept = best_valid && (best_lvl > cur_lvl) && (mode_reg == MODE_RUN);
    end

    // Vector request stays up until the CPU takes it.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
        begin
            vec_o <= '0;
            serv_reg <= '0;
            last_vec_reg <= '0;
        end
        else
        begin
            if (vec_o.valid && vec_ack_i)
            begin
                vec_o.valid <= 1'b0;
                serv_reg[vec_o.lvl - 2'd1] <= 1'b1;
                last_vec_reg <= vec_o.num;
            end
            else if (!vec_o.valid && accept)
            begin
                vec_o.valid <= 1'b1;
                vec_o.num <= best_num;
                vec_o.lvl <= best_lvl;
                vec_o.addr <= VEC_BASE_ADDR + (20'(best_num) << VEC_STEP_SHIFT);
            end
            if (reti_i && !(vec_o.valid && vec_ack_i))
            begin
                // Return from the handler closes the highest open level.
                if (serv_reg[2])
                    serv_reg[2] <= 1'b0;
                else if (serv_reg[1])
                    serv_reg[1] <= 1'b0;
                else
                    serv_reg[0] <= 1'b0;
            end
        end
    end

    // Standby mode transitions.
    always_comb
    begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_RUN:
            begin
                if (wr_ctrl && wb_sel_i[0])
                    mode_next = standby_e'(wb_dat_i[CTRL_MODE_LSB +: 2]);
            end
            MODE_HALT:
            begin
                if (|(flag_reg & mask_reg))
                    mode_next = MODE_RUN;
            end
            MODE_HOLD, MODE_XHOLD:
            begin
                if (|src_set)
                    mode_next = MODE_RUN;
            end
            default: mode_next = MODE_RUN;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
            mode_reg <= MODE_RUN;
        else
            mode_reg <= mode_next;
    end

    // Run and oscillator enables; the crystal holds its state in crystal hold.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
        begin
            cpu_run_o <= 1'b0;
            periph_run_o <= 1'b0;
            keep_alive_run_o <= 1'b0;
            osc_cf_en_o <= 1'b0;
            osc_rc_en_o <= 1'b0;
            osc_xt_en_o <= 1'b0;
        end
        else
        begin
            cpu_run_o <= (mode_reg == MODE_RUN);
            periph_run_o <= (mode_reg == MODE_RUN) || (mode_reg == MODE_HALT);
            keep_alive_run_o <= (mode_reg != MODE_HOLD);
            osc_cf_en_o <= !cf_off_reg && (mode_reg == MODE_RUN || mode_reg == MODE_HALT);
            osc_rc_en_o <= !rc_off_reg && (mode_reg == MODE_RUN || mode_reg == MODE_HALT);
            if (mode_reg == MODE_HOLD)
                osc_xt_en_o <= 1'b0;
            else if (mode_reg != MODE_XHOLD)
                osc_xt_en_o <= !xt_off_reg;
        end
    end

    // Level interrupt from flags that will stand next cycle.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
            irq_o <= 1'b0;
        else
            irq_o <= |(flag_next & mask_reg);
    end

    // Read mux; unmapped addresses read zero and still acknowledge.
    always_comb
    begin
        rd_data = '0;
        case (wb_adr_i)
            ADDR_CTRL:
            begin
                rd_data[CTRL_MODE_LSB +: 2] = mode_reg;
                rd_data[CTRL_CF_OFF] = cf_off_reg;
                rd_data[CTRL_XT_OFF] = xt_off_reg;
                rd_data[CTRL_RC_OFF] = rc_off_reg;
                rd_data[CTRL_LVLDET_LSB +: NUM_EXT] = lvldet_reg;
            end
            ADDR_LEVEL: rd_data[NUM_VEC-1:0] = lvlsel_reg;
            ADDR_FLAG: rd_data[23:0] = flag_reg;
            ADDR_MASK: rd_data[23:0] = mask_reg;
            ADDR_LIST:
            begin
                rd_data[23:0] = flag_reg & VEC_SRC_MASK[last_vec_reg];
                rd_data[LIST_VEC_LSB +: 4] = last_vec_reg;
            end
            ADDR_STAT:
            begin
                rd_data[1:0] = mode_reg;
                rd_data[STAT_SERV_LSB +: 3] = serv_reg;
            end
            default: rd_data = '0;
        endcase
    end

    // Acknowledge one cycle after the request; dropped the cycle after.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req)
                wb_dat_o <= rd_data;
        end
    end

    property p_accept_above;
        @(posedge clk_i) disable iff (rst_i)
        $rose(vec_o.valid) |-> vec_o.lvl > cur_lvl;
    endproperty
    a_accept_above: assert property (p_accept_above) else $error("Low level vector raised.");

    property p_x_blocks_all;
        @(posedge clk_i) disable iff (rst_i)
        serv_reg[2] && !sys_rst |=> !$rose(vec_o.valid);
    endproperty
    a_x_blocks_all: assert property (p_x_blocks_all) else $error("Request under X service.");

    property p_pick_best;
        @(posedge clk_i) disable iff (rst_i)
        !vec_o.valid && accept && !sys_rst |=> vec_o.valid && vec_o.num == $past(best_num);
    endproperty
    a_pick_best: assert property (p_pick_best) else $error("Wrong vector chosen.");

    property p_vec_map;
        @(posedge clk_i) disable iff (rst_i)
        vec_o.valid |-> vec_o.addr == VEC_BASE_ADDR + (20'(vec_o.num) << VEC_STEP_SHIFT)
            && (vec_o.num < 4'd2 || vec_o.lvl != LVL_X);
    endproperty
    a_vec_map: assert property (p_vec_map) else $error("Vector address or level wrong.");

    property p_halt_wake;
        @(posedge clk_i) disable iff (rst_i)
        mode_reg == MODE_HALT && |(flag_reg & mask_reg) |=> mode_reg == MODE_RUN ##1 cpu_run_o;
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("Halt not left.");

    property p_hold_stop;
        @(posedge clk_i) disable iff (rst_i)
        mode_reg == MODE_HOLD && !sys_rst |=> !osc_cf_en_o && !osc_rc_en_o && !osc_xt_en_o
            && !periph_run_o && !cpu_run_o;
    endproperty
    a_hold_stop: assert property (p_hold_stop) else $error("Hold left something running.");

    property p_edge_no_wake;
        @(posedge clk_i) disable iff (rst_i)
        mode_reg == MODE_HOLD && !lvldet_reg[0] && !sys_rst |-> !src_set[0];
    endproperty
    a_edge_no_wake: assert property (p_edge_no_wake) else $error("Edge input woke hold.");

    property p_xhold_keep;
        @(posedge clk_i) disable iff (rst_i)
        mode_reg == MODE_XHOLD && !sys_rst |=> $stable(osc_xt_en_o) && keep_alive_run_o;
    endproperty
    a_xhold_keep: assert property (p_xhold_keep) else $error("Crystal state lost.");

    property p_reset_osc;
        @(posedge clk_i)
        sys_rst |=> !osc_cf_en_o && !osc_xt_en_o;
    endproperty
    a_reset_osc: assert property (p_reset_osc) else $error("Oscillator ran in reset.");
endmodule : irq_priority_standby_wake

// >>> shared/irq_wake_pkg.sv
// Constants, types and register map of the interrupt priority and standby wake-up block.
package irq_wake_pkg;
    localparam int NUM_SRC = 24;
    localparam int NUM_VEC = 10;
    localparam int NUM_EXT = 5;
    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_FLAG = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0c;
    localparam logic [7:0] ADDR_LIST = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    // Control register fields.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CF_OFF = 4;
    localparam int CTRL_XT_OFF = 5;
    localparam int CTRL_RC_OFF = 6;
    localparam int CTRL_LVLDET_LSB = 8;
    // Status and list register fields.
    localparam int STAT_SERV_LSB = 4;
    localparam int LIST_VEC_LSB = 28;
    // Source index of each external pin: inputs 0, 1, 2, 4 and 5.
    localparam int EXT_SRC [NUM_EXT] = '{0, 1, 2, 4, 7};
    // Sources that may still raise events in the two hold modes.
    localparam logic [23:0] HOLD_WAKE_SRC = 24'h100097;
    localparam logic [23:0] XHOLD_EXTRA_SRC = 24'h000320;
    // Sources sharing each vector.
    localparam logic [23:0] VEC_SRC_MASK [NUM_VEC] = '{
        24'h000001, 24'h000002, 24'h00003c, 24'h0003c0, 24'h000400,
        24'h001800, 24'h006000, 24'h018000, 24'h0e0000, 24'hf00000};
    localparam logic [19:0] VEC_BASE_ADDR = 20'h00003;
    localparam int VEC_STEP_SHIFT = 3;
    localparam logic [5:0] PIN_IDLE = 6'h01;

    typedef enum logic [1:0] {
        LVL_NONE = 2'b00,
        LVL_L = 2'b01,
        LVL_H = 2'b10,
        LVL_X = 2'b11
    } level_e;

    // Gray-coded along run, halt, hold, crystal hold.
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_HALT = 2'b01,
        MODE_HOLD = 2'b11,
        MODE_XHOLD = 2'b10
    } standby_e;

    typedef struct packed {
        logic valid;
        logic [19:0] addr;
        logic [3:0] num;
        level_e lvl;
    } vec_req_s;
endpackage : irq_wake_pkg

// >>> tb/cpu_vec_model.sv
// Behavioural CPU core that takes interrupt vectors and returns from handlers.
`timescale 1ns/10ps
module cpu_vec_model
    import irq_wake_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Vector handshake.
    input wire vec_req_s vec_i,
    output logic vec_ack_o,
    output logic reti_o
);
    int ack_dly = 1;
    int n_taken = 0;
    logic [3:0] last_num = '0;

    // Waits a settable time before taking a vector, so slow answers are exercised too.
    initial
    begin
        vec_ack_o = 1'b0;
        reti_o = 1'b0;
        forever
        begin
            @(posedge clk_i);
            if (rst_i === 1'b0 && vec_i.valid === 1'b1)
            begin
                repeat (ack_dly) @(posedge clk_i);
                vec_ack_o <= 1'b1;
                last_num <= vec_i.num;
                @(posedge clk_i);
                vec_ack_o <= 1'b0;
                n_taken++;
            end
        end
    end

    // One-cycle return from the current handler.
    task pulse_reti;
        @(posedge clk_i);
        reti_o <= 1'b1;
        @(posedge clk_i);
        reti_o <= 1'b0;
    endtask : pulse_reti
endmodule : cpu_vec_model

// >>> tb/irq_priority_standby_wake_bench.sv
// Self-checking bench for interrupt priority and standby wake-up.
`timescale 1ns/10ps
module irq_priority_standby_wake_bench
    import irq_wake_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wdt = 1'b0;
    logic [7:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] wdat = '0, rdat, dato;
    logic [4:0] ext = '0;
    logic [23:0] evt = '0;
    logic ack, irq, cpu_run, periph_run, keep_run, cf_en, rc_en, xt_en, vack, reti;
    vec_req_s vec_w;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;

    // Free-running system clock.
    always #50 clk_i = ~clk_i;

    irq_priority_standby_wake u_irq_priority_standby_wake (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
        .res_n_i(1'b1), .wdt_rst_i(wdt), .ext_irq_in_0_i(ext[0]), .ext_irq_in_1_i(ext[1]),
        .ext_irq_in_2_i(ext[2]), .ext_irq_in_4_i(ext[3]), .ext_irq_in_5_i(ext[4]),
        .periph_evt_i(evt), .vec_o(vec_w), .vec_ack_i(vack), .reti_i(reti), .irq_o(irq),
        .cpu_run_o(cpu_run), .periph_run_o(periph_run), .keep_alive_run_o(keep_run),
        .osc_cf_en_o(cf_en), .osc_rc_en_o(rc_en), .osc_xt_en_o(xt_en));

    cpu_vec_model u_cpu_vec_model (
        .clk_i(clk_i), .rst_i(rst_i), .vec_i(vec_w), .vec_ack_o(vack), .reti_o(reti));

    task automatic stop_test;
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle

    // Classic single cycle; outputs are read in the active region, before the edge lands.
    // It waits for acknowledge with no limit of its own, so only the bench timeout ends a hang.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        rdat = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic pulse(input logic [23:0] m);
        @(posedge clk_i);
        evt <= m;
        @(posedge clk_i);
        evt <= '0;
    endtask : pulse

    task automatic wait_run(input logic v);
        int n;
        n = 0;
        while (cpu_run !== v && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(cpu_run, v);
    endtask : wait_run

    task automatic wait_taken(input int k, input logic [3:0] num);
        int n;
        n = 0;
        while (u_cpu_vec_model.n_taken < k && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(u_cpu_vec_model.n_taken >= k, 1'b1);
        chk(u_cpu_vec_model.last_num, num);
    endtask : wait_taken

    // Clears flags and unwinds up to two handlers still in service.
    task automatic tidy;
        wb(1'b1, ADDR_FLAG, 32'h00ffffff);
        u_cpu_vec_model.pulse_reti();
        u_cpu_vec_model.pulse_reti();
        idle(4);
    endtask : tidy

    task automatic t_reset;
        chk(cf_en, 1'b0);
        rst_i <= 1'b0;
        idle(4);
        chk({cpu_run, periph_run, cf_en, rc_en, xt_en}, 5'h1f);
        wb(1'b0, ADDR_STAT, '0);
        chk(rdat, 32'h0);
        wb(1'b0, 8'hfc, '0);
        chk(rdat, 32'h0);
    endtask : t_reset

    // High level beats a smaller address, equal levels go by address, in-service level blocks.
    task automatic t_priority;
        int n0;
        n0 = u_cpu_vec_model.n_taken;
        u_cpu_vec_model.ack_dly = 4;
        wb(1'b1, ADDR_MASK, 32'h00ffffff);
        wb(1'b1, ADDR_LEVEL, 32'h40);
        pulse(24'h002008);
        idle(2);
        chk(vec_w.valid, 1'b1);
        chk(vec_w.addr, 20'h00033);
        chk(vec_w.lvl, LVL_H);
        wait_taken(n0 + 1, 4'd6);
        wb(1'b1, ADDR_FLAG, 32'h2000);
        idle(6);
        chk(vec_w.valid, 1'b0);
        u_cpu_vec_model.pulse_reti();
        wait_taken(n0 + 2, 4'd2);
        wb(1'b0, ADDR_LIST, '0);
        chk(rdat, 32'h20000008);
        tidy();
        // Pin 0 on the top level outranks high and holds it off while in service.
        wb(1'b1, ADDR_LEVEL, 32'h41);
        ext[0] <= 1'b1;
        idle(5);
        chk(vec_w.lvl, LVL_X);
        chk(vec_w.addr, 20'h00003);
        pulse(24'h002000);
        wait_taken(n0 + 3, 4'd0);
        idle(6);
        chk(vec_w.valid, 1'b0);
        ext[0] <= 1'b0;
        wb(1'b1, ADDR_FLAG, 32'h1);
        u_cpu_vec_model.pulse_reti();
        wait_taken(n0 + 4, 4'd6);
        tidy();
        wb(1'b1, ADDR_LEVEL, 32'h0);
        pulse(24'h004800);
        wait_taken(n0 + 5, 4'd5);
        tidy();
    endtask : t_priority

    task automatic t_irq;
        wb(1'b1, ADDR_MASK, 32'h0);
        pulse(24'h000008);
        idle(3);
        chk(irq, 1'b0);
        wb(1'b1, ADDR_MASK, 32'h8);
        idle(2);
        chk(irq, 1'b1);
        wb(1'b1, ADDR_FLAG, 32'h8);
        idle(2);
        chk(irq, 1'b0);
        wb(1'b1, ADDR_MASK, 32'h00ffffff);
        tidy();
    endtask : t_irq

    task automatic t_halt;
        wb(1'b1, ADDR_CTRL, 32'h1);
        idle(3);
        chk({cpu_run, periph_run, cf_en, rc_en, xt_en}, 5'h0f);
        pulse(24'h002000);
        wait_run(1'b1);
        tidy();
    endtask : t_halt

    // Edge-mode pin 0 and a timer source must not end hold; pin 2 must.
    task automatic t_hold;
        wb(1'b1, ADDR_CTRL, 32'h3);
        idle(3);
        chk({cpu_run, periph_run, cf_en, rc_en, xt_en}, 5'h00);
        pulse(24'h002000);
        ext[0] <= 1'b1;
        idle(8);
        chk(cpu_run, 1'b0);
        ext[0] <= 1'b0;
        idle(3);
        ext[2] <= 1'b1;
        wait_run(1'b1);
        ext[2] <= 1'b0;
        tidy();
        wb(1'b1, ADDR_CTRL, 32'h103);
        idle(3);
        chk(cpu_run, 1'b0);
        ext[0] <= 1'b1;
        wait_run(1'b1);
        ext[0] <= 1'b0;
        // Let the low level pass the synchroniser, or the clear loses to a fresh set.
        idle(3);
        tidy();
    endtask : t_hold

    task automatic t_xhold;
        wb(1'b1, ADDR_CTRL, 32'h2);
        idle(3);
        chk({cpu_run, periph_run, keep_run, cf_en, xt_en}, 5'h05);
        pulse(24'h000100);
        wait_run(1'b1);
        tidy();
    endtask : t_xhold

    task automatic t_wdt;
        wb(1'b1, ADDR_CTRL, 32'h41);
        idle(3);
        chk({cpu_run, periph_run, cf_en, rc_en, xt_en}, 5'h0d);
        wdt <= 1'b1;
        idle(3);
        chk({cf_en, xt_en}, 2'b00);
        wdt <= 1'b0;
        idle(3);
        chk({cpu_run, cf_en}, 2'b11);
    endtask : t_wdt

    // Cuts a hang short well beyond the few hundred cycles the run needs.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    // Reset is held for twenty cycles, then the scenarios run in turn.
    initial
    begin
        idle(20);
        t_reset();
        t_priority();
        t_irq();
        t_halt();
        t_hold();
        t_xhold();
        t_wdt();
        stop_test();
    end
endmodule : irq_priority_standby_wake_bench
